// ===== hw/msi_pkg.sv
// Constants and types for the modem status input block
package msi_pkg;

    // ************************************************************
    // Register map (byte addresses, one word per register)
    // ************************************************************
    localparam int         MSI_ADDR_W    = 8;
    localparam logic [7:0] MSI_MSR_BASE  = 8'h00;
    localparam logic [7:0] MSI_IER_BASE  = 8'h10;
    localparam logic [7:0] MSI_IRQ_STAT  = 8'h20;
    localparam logic [7:0] MSI_IRQ_MASK  = 8'h24;
    localparam logic [7:0] MSI_PORT_STEP = 8'h04;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int         MSI_MAX_PORTS  = 4;
    localparam int         MSI_DELTA_LSB  = 0;
    localparam int         MSI_LEVEL_LSB  = 4;
    localparam int         MSI_IER_MODEM  = 3;
    localparam logic [7:0] MSI_IER_RST    = 8'h00;
    localparam logic [3:0] MSI_DELTA_RST  = 4'h0;
    localparam logic [3:0] MSI_SYNC_RST   = 4'hF;
    localparam logic [3:0] MSI_STAT_RST   = 4'h0;
    localparam logic [3:0] MSI_MASK_RST   = 4'hF;
    localparam logic [1:0] MSI_HTRANS_NSQ = 2'h2;

    // ************************************************************
    // Types
    // ************************************************************
    // Bit 0 is clear to send, bit 3 carrier detect; all active low
    typedef struct packed {
        logic dcd_n;
        logic ri_n;
        logic dsr_n;
        logic cts_n;
    } msi_modem_t;

    typedef struct packed {
        logic                  wr;
        logic [MSI_ADDR_W-1:0] addr;
    } msi_wphase_t;

endpackage : msi_pkg

// ===== hw/msi_top.sv
// Modem status inputs for several serial ports behind an AHB-Lite slave
//
// The AHB-Lite slave port and the address map were chosen for this implementation.
module msi_top
    import msi_pkg::*;
#(
    parameter int NUM_PORTS = 2
)
(
    input  wire logic                            core_clk_in,
    input  wire logic                            sys_rst_in,
    input  wire logic                            ce_in,
    input  wire msi_pkg::msi_modem_t [NUM_PORTS-1:0] modem_n_in,
    input  wire logic                            hsel_in,
    input  wire logic [31:0]                     haddr_in,
    input  wire logic [1:0]                      htrans_in,
    input  wire logic                            hwrite_in,
    input  wire logic [2:0]                      hsize_in,
    input  wire logic [31:0]                     hwdata_in,
    input  wire logic                            hready_in,
    output logic      [31:0]                     hrdata_out,
    output logic                                 hreadyout_out,
    output logic                                 hresp_out,
    output logic                                 irq_out
);
    import msi_pkg::*;

    // ************************************************************
    // Parameter check
    // ************************************************************
    generate
        if (NUM_PORTS < 1 || NUM_PORTS > MSI_MAX_PORTS)
        begin : g_bad_ports
            $error("msi_top: NUM_PORTS out of range");
        end
    endgenerate

    // ************************************************************
    // State
    // ************************************************************
    logic [NUM_PORTS-1:0][3:0] sync1;
    logic [NUM_PORTS-1:0][3:0] sync2;
    logic [NUM_PORTS-1:0][3:0] prev;
    logic [NUM_PORTS-1:0][3:0] delta;
    logic [NUM_PORTS-1:0][7:0] interrupt_enable_reg;
    logic [3:0]                irq_stat;
    logic [3:0]                irq_mask;
    msi_wphase_t               wph;

    logic [NUM_PORTS-1:0][3:0] next_sync1;
    logic [NUM_PORTS-1:0][3:0] next_sync2;
    logic [NUM_PORTS-1:0][3:0] next_prev;
    logic [NUM_PORTS-1:0][3:0] next_delta;
    logic [NUM_PORTS-1:0][7:0] next_ier;
    logic [3:0]                next_irq_stat;
    logic [3:0]                next_irq_mask;
    msi_wphase_t               next_wph;
    logic [31:0]               next_hrdata;
    logic                      next_irq;

    // ************************************************************
    // Address phase decode
    // ************************************************************
    logic                  aph_valid;
    logic                  aph_rd;
    logic [MSI_ADDR_W-1:0] aph_addr;
    logic                  wr_stat;
    logic                  wr_mask;

    assign aph_valid = hsel_in & hready_in & (htrans_in == MSI_HTRANS_NSQ);
    assign aph_rd    = aph_valid & ~hwrite_in;
    assign aph_addr  = haddr_in[MSI_ADDR_W-1:0];
    assign wr_stat   = wph.wr & (wph.addr == MSI_IRQ_STAT);
    assign wr_mask   = wph.wr & (wph.addr == MSI_IRQ_MASK);

    // ************************************************************
    // Per-port status logic
    // ************************************************************
    logic [NUM_PORTS-1:0][3:0] rise;
    logic [NUM_PORTS-1:0]      change;
    logic [NUM_PORTS-1:0]      msr_rd;
    logic [NUM_PORTS-1:0]      ier_rd;
    logic [NUM_PORTS-1:0]      ier_wr;
    logic [NUM_PORTS-1:0][7:0] msr_val;

    generate
        for (genvar i = 0; i < NUM_PORTS; i++)
        begin : g_port
            localparam logic [7:0] MSR_OFS =
                MSI_MSR_BASE + 8'(i * 4);
            localparam logic [7:0] IER_OFS =
                MSI_IER_BASE + 8'(i * 4);

            // Pin going from low to high
            assign rise[i]   = sync2[i] & ~prev[i];
            assign change[i] = |(sync2[i] ^ prev[i]);
            assign msr_rd[i] = aph_rd & (aph_addr == MSR_OFS);
            assign ier_rd[i] = aph_rd & (aph_addr == IER_OFS);
            assign ier_wr[i] = wph.wr & (wph.addr == IER_OFS);
            // Levels inverted, index i lines up level and change bit
            // Clear to send goes only to status and interrupt: no transmit gating
            assign msr_val[i] = {~sync2[i], delta[i]};
        end
    endgenerate

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb
    begin
        next_sync1    = modem_n_in;
        next_sync2    = sync1;
        next_prev     = sync2;
        next_delta    = delta;
        next_ier      = interrupt_enable_reg;
        next_irq_stat = irq_stat;
        next_irq_mask = irq_mask;
        next_hrdata   = 32'h0000_0000;
        next_wph.wr   = aph_valid & hwrite_in;
        next_wph.addr = aph_addr;

        for (int i = 0; i < NUM_PORTS; i++)
        begin
            // A rise in the read cycle survives the clear
            if (msr_rd[i])
            begin
                next_delta[i] = MSI_DELTA_RST;
            end
            next_delta[i] = next_delta[i] | rise[i];
            if (ier_wr[i])
            begin
                next_ier[i] = hwdata_in[7:0];
            end
            if (msr_rd[i])
            begin
                next_hrdata[7:0] = msr_val[i];
            end
            if (ier_rd[i])
            begin
                next_hrdata[7:0] = interrupt_enable_reg[i];
            end
        end

        if (wr_stat)
        begin
            next_irq_stat = irq_stat & ~hwdata_in[3:0];
        end
        if (wr_mask)
        begin
            next_irq_mask = hwdata_in[3:0];
        end
        for (int i = 0; i < NUM_PORTS; i++)
        begin
            // Set wins over a write-one clear in the same cycle
            if (change[i] && interrupt_enable_reg[i][MSI_IER_MODEM])
            begin
                next_irq_stat[i] = 1'b1;
            end
        end

        if (aph_rd && aph_addr == MSI_IRQ_STAT)
        begin
            next_hrdata[3:0] = irq_stat;
        end
        if (aph_rd && aph_addr == MSI_IRQ_MASK)
        begin
            next_hrdata[3:0] = irq_mask;
        end

        next_irq = |(next_irq_stat & next_irq_mask);
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            for (int i = 0; i < NUM_PORTS; i++)
            begin
                sync1[i] <= MSI_SYNC_RST;
                sync2[i] <= MSI_SYNC_RST;
                prev[i]  <= MSI_SYNC_RST;
                delta[i] <= MSI_DELTA_RST;
                interrupt_enable_reg[i]   <= MSI_IER_RST;
            end
            irq_stat      <= MSI_STAT_RST;
            irq_mask      <= MSI_MASK_RST;
            wph.wr        <= 1'b0;
            wph.addr      <= '0;
            hrdata_out    <= 32'h0000_0000;
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
            irq_out       <= 1'b0;
        end
        else if (ce_in)
        begin
            sync1         <= next_sync1;
            sync2         <= next_sync2;
            prev          <= next_prev;
            delta         <= next_delta;
            interrupt_enable_reg           <= next_ier;
            irq_stat      <= next_irq_stat;
            irq_mask      <= next_irq_mask;
            wph           <= next_wph;
            hrdata_out    <= next_hrdata;
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
            irq_out       <= next_irq;
        end
    end

endmodule : msi_top

// ===== verif/msi_top_asserts.sv
// Checker on the ports of the modem status block
module msi_top_asserts
    import msi_pkg::*;
#(
    parameter int NUM_PORTS = 2
)
(
    input wire logic                                 core_clk_in,
    input wire logic                                 sys_rst_in,
    input wire logic                                 ce_in,
    input wire msi_pkg::msi_modem_t [NUM_PORTS-1:0] modem_n_in,
    input wire logic                                 hsel_in,
    input wire logic [31:0]                          haddr_in,
    input wire logic [1:0]                           htrans_in,
    input wire logic                                 hwrite_in,
    input wire logic [2:0]                           hsize_in,
    input wire logic [31:0]                          hwdata_in,
    input wire logic                                 hready_in,
    input wire logic [31:0]                          hrdata_out,
    input wire logic                                 hreadyout_out,
    input wire logic                                 hresp_out,
    input wire logic                                 irq_out
);
    // ****************************************
    // Helpers and properties
    // ****************************************
    logic       ap;
    logic       rd;
    logic       rd0;
    logic       wr_irq;
    logic [3:0] m0_q;
    logic [3:0] rise0;
    logic       wr_msk;
    logic [2:0] st0 = 3'h0;
    assign ap = hsel_in && hready_in && htrans_in == MSI_HTRANS_NSQ;
    assign wr_msk = ap && hwrite_in && haddr_in[7:0] == MSI_IRQ_MASK;
    assign rd = ap && !hwrite_in;
    assign rd0 = rd && haddr_in[7:0] == 8'h00;
    assign wr_irq = ap && hwrite_in && haddr_in[7:0] == MSI_IRQ_STAT;
    // Rising pins of port 0, one tick late
    always_ff @(posedge core_clk_in)
    begin
        m0_q  <= modem_n_in[0];
        rise0 <= modem_n_in[0] & ~m0_q;
        // Cycles port 0 pins have held still, saturating
        if (modem_n_in[0] != m0_q)
            st0 <= 3'h0;
        else if (st0 != 3'h7)
            st0 <= st0 + 3'h1;
    end
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);
    property p_lvl0;
        rd0 && $stable(modem_n_in[0]) && $past(modem_n_in[0]) ==
        $past(modem_n_in[0], 2) |=> hrdata_out[7:4] == ~$past(modem_n_in[0]);
    endproperty
    a_lvl0: assert property (p_lvl0) else $error("level bits wrong");
    property p_lvl1;
        rd && haddr_in[7:0] == 8'h04 && $stable(modem_n_in[1]) &&
        $past(modem_n_in[1]) == $past(modem_n_in[1], 2)
        |=> hrdata_out[7:4] == ~$past(modem_n_in[1]);
    endproperty
    a_lvl1: assert property (p_lvl1) else $error("port 1 level wrong");
    property p_clr0;
        rd0 ##2 (rd0 && st0 >= 3'h4) |=> hrdata_out[3:0] == 4'h0;
    endproperty
    a_clr0: assert property (p_clr0) else $error("change bits kept");
    property p_rise0;
        rd0 && $past(rise0, 2) != 4'h0
        |=> (hrdata_out[3:0] & $past(rise0, 3)) == $past(rise0, 3);
    endproperty
    a_rise0: assert property (p_rise0) else $error("change bit missed");
    property p_irq_rose;
        $rose(irq_out) |-> $past(modem_n_in, 3) != $past(modem_n_in, 4) ||
        $past(wr_msk, 2);
    endproperty
    a_irq_rose: assert property (p_irq_rose) else $error("irq without pin change");
    property p_irq_fell;
        $fell(irq_out) |-> $past(wr_irq, 2) || $past(wr_irq, 3) ||
        $past(wr_msk, 2);
    endproperty
    a_irq_fell: assert property (p_irq_fell) else $error("irq dropped alone");
    property p_ready;
        hreadyout_out && !hresp_out;
    endproperty
    a_ready: assert property (p_ready) else $error("bus not ready or error");
    property p_idle;
        !$past(rd) |-> hrdata_out == 32'h0;
    endproperty
    a_idle: assert property (p_idle) else $error("read data outside reads");
endmodule : msi_top_asserts

bind msi_top msi_top_asserts #(.NUM_PORTS(NUM_PORTS)) asserts_i (.*);

// ===== verif/msi_modem_model.sv
// Behavioural modem driving the handshake lines of every port
module msi_modem_model
    import msi_pkg::*;
#(
    parameter int NUM_PORTS = 2
)
(
    input  wire logic                           core_clk_in,
    output msi_pkg::msi_modem_t [NUM_PORTS-1:0] modem_n_out
);
    initial modem_n_out = '1;
    // Lines move just after an edge and hold for cycles, never glitch
    task automatic set_pin(input int p, input logic [3:0] v);
        @(posedge core_clk_in);
        modem_n_out[p] <= v;
    endtask : set_pin
endmodule : msi_modem_model

// ===== verif/tb.sv
// Self-checking bench for the modem status block
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import msi_pkg::*;
    // ****************************************
    // Signals, tasks and tests
    // ****************************************
    logic                   clk = 1'b0;
    logic                   rst = 1'b1;
    logic                   hsel = 1'b0;
    logic [31:0]            haddr = 32'h0;
    logic [1:0]             htrans = 2'h0;
    logic                   hwrite = 1'b0;
    logic [31:0]            hwdata = 32'h0;
    logic [31:0]            hrdata;
    logic                   hrdy;
    logic                   hresp;
    logic                   irq;
    logic [31:0]            rd;
    msi_modem_t [1:0]       pins;
    int                     err_count = 0;
    int                     n_tests = 0;
    always #2 clk = ~clk;
    msi_modem_model #(.NUM_PORTS(2)) msi_modem_model_i (.core_clk_in(clk),
        .modem_n_out(pins));
    msi_top #(.NUM_PORTS(2)) msi_top_i (.core_clk_in(clk), .sys_rst_in(rst),
        .ce_in(1'b1), .modem_n_in(pins), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
        .hwdata_in(hwdata), .hready_in(hrdy), .hrdata_out(hrdata),
        .hreadyout_out(hrdy), .hresp_out(hresp), .irq_out(irq));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Called just after an edge; returns at the edge that ends the data phase
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        hsel <= 1'b1; haddr <= {24'h0, a}; hwrite <= w; htrans <= 2'h2;
        do @(posedge clk); while (hrdy !== 1'b1);
        htrans <= 2'h0; hwdata <= d;
        do @(posedge clk); while (hrdy !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rchk
    task automatic pin(input int p, input logic [3:0] v);
        msi_modem_model_i.set_pin(p, v);
        repeat (3) @(posedge clk);
    endtask : pin
    task automatic end_of_test();
        $display("errors %0d of %0d checks", err_count, n_tests);
        if (err_count == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_of_test
    initial
    begin
        #40000;
        err_count++;
        end_of_test();
    end
    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rchk(MSI_IRQ_MASK, 32'hF);
        rchk(8'h00, 32'h0);
        rchk(8'h10, 32'h0);
        bus(1'b1, 8'h10, 32'h8);
        rchk(8'h10, 32'h8);
        for (int b = 0; b < 4; b++)
        begin
            pin(0, 4'hF & ~(4'h1 << b));
            rchk(8'h00, 32'h10 << b);
            chk({31'h0, irq}, 32'h1);
            bus(1'b1, MSI_IRQ_STAT, 32'h1);
            repeat (2) @(posedge clk);
            chk({31'h0, irq}, 32'h0);
            pin(0, 4'hF);
            rchk(8'h00, 32'h1 << b);
            rchk(8'h00, 32'h0);
            rchk(MSI_IRQ_STAT, 32'h1);
            bus(1'b1, MSI_IRQ_STAT, 32'h1);
        end
        pin(1, 4'hE);
        rchk(8'h04, 32'h10);
        rchk(8'h00, 32'h0);
        rchk(MSI_IRQ_STAT, 32'h0);
        bus(1'b1, MSI_IRQ_MASK, 32'h0);
        pin(0, 4'hE);
        rchk(MSI_IRQ_STAT, 32'h1);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, MSI_IRQ_STAT, 32'h1);
        bus(1'b1, MSI_IRQ_MASK, 32'hF);
        rchk(8'h40, 32'h0);
        bus(1'b1, 8'h00, 32'hFF);
        rchk(8'h00, 32'h10);
        end_of_test();
    end
endmodule : tb
